/* File: bench/odc_orient_debounce_test.sv */
// Bench: register access, angle decoding and debounce timing of the orientation block
`timescale 1ns/10ps
`default_nettype none
module odc_orient_debounce_test;
  import odc_pkg::*;
  localparam logic [8:0] TMIN [8] = '{9'h088, 9'h0AB, 9'h0CF, 9'h0F4, 9'h119, 9'h140, 9'h169, 9'h194};
  localparam logic [8:0] TMAX [8] = '{9'h091, 9'h0B6, 9'h0DC, 9'h103, 9'h12C, 9'h156, 9'h183, 9'h1B2};
  localparam logic [9:0] L2P [8] = '{10'h1C2, 10'h1EA, 10'h208, 10'h230, 10'h24E, 10'h26C, 10'h294,
    10'h2B2};
  localparam logic [9:0] P2L [8] = '{10'h1C2, 10'h19A, 10'h17C, 10'h154, 10'h136, 10'h118, 10'h0F0,
    10'h0D2};
  localparam logic [6:0] B2F [4] = '{7'h50, 7'h4B, 7'h46, 7'h41};
  logic aclk, aresetn;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd_d;
  logic [3:0] wstrb, orient_now;
  logic [1:0] bresp, rresp, resp;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic high_g, sleep_state, pose_changed_flag, irq;
  int n_errors, checked, cyc, tflag, per;

  odc_orient_debounce u_odc_orient_debounce (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .orient_now(orient_now), .high_g(high_g), .sleep_state(sleep_state),
    .pose_changed_flag(pose_changed_flag), .irq(irq)
  );

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Hang guard, generous against a run of under a thousand cycles
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      wrap_up();
    end
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rd_d = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  // Orientation changes on the edge that raises a tick, one cycle before the engine samples it, so a hold spans whole sample periods
  task automatic hold(input logic [3:0] o, input int q);
    int bad;
    bad = 0;
    while ((cyc - tflag) % per != 1) @(posedge aclk);
    orient_now <= o;
    repeat (q) begin
      @(posedge aclk);
      if (pose_changed_flag !== 1'b0) bad = 1;
    end
    chk("early flag", bad, 0);
  endtask

  task automatic fin(input logic [3:0] o, input int lim, input logic ei);
    int n;
    n = 0;
    while (pose_changed_flag !== 1'b1 && n < lim) begin
      @(posedge aclk);
      n++;
    end
    tflag = cyc;
    chk("flag", {31'h0, pose_changed_flag}, 32'h1);
    rd(8'hA0);
    chk("state", rd_d, {24'h0, 1'b1, o[3], 3'h0, o[2:0]});
    chk("irq", {31'h0, irq}, {31'h0, ei});
    chk("flag after read", {31'h0, pose_changed_flag}, 32'h0);
    rd(8'hC0);
    chk("irq stat set", rd_d, 32'h1);
    wr(8'hC0, 32'h1);
    rd(8'hC0);
    chk("irq stat clear", rd_d, 32'h0);
    chk("irq clear", {31'h0, irq}, 32'h0);
  endtask

  initial begin
    aresetn = 1'b0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'h1;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    orient_now = 4'h0;
    high_g = 1'b0;
    sleep_state = 1'b0;
    n_errors = 0;
    checked = 0;
    cyc = 0;
    tflag = 0;
    per = 4;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'hA8);
    chk("count reset", rd_d, 32'h0);
    rd(8'hAC);
    chk("flip tilt reset", rd_d, 32'h44);
    rd(8'hB0);
    chk("thresh reset", rd_d, 32'h84);
    rd(8'hA4);
    chk("setup reset", rd_d, 32'h80);
    rd(8'hFC);
    chk("unmapped data", rd_d, 32'h0);
    chk("unmapped rresp", {30'h0, resp}, {30'h0, ODC_RESP_SLVERR});
    wr(8'hFC, 32'h5A);
    chk("unmapped bresp", {30'h0, resp}, {30'h0, ODC_RESP_SLVERR});
    wr(8'hA8, 32'hA5);
    rd(8'hA8);
    chk("count rw", rd_d, 32'hA5);
    for (int k = 0; k < 8; k++) begin
      wr(8'hAC, {24'h0, k[1:0], 3'h0, k[2:0]});
      wr(8'hB0, {24'h0, 5'h10, k[2:0]});
      rd(8'hAC);
      chk("flip tilt rw", rd_d, {24'h0, k[1:0], 3'h0, k[2:0]});
      rd(8'hB0);
      chk("thresh rw", rd_d, {24'h0, 5'h10, k[2:0]});
      rd(8'hD4);
      chk("angles", rd_d, {6'h0, 10'h1C2, TMIN[k], B2F[k % 4]});
      rd(8'hD8);
      chk("trip angles", rd_d, {3'h0, TMAX[k], L2P[k], P2L[k]});
    end
    wr(8'hB0, 32'h0);
    rd(8'hD4);
    chk("thr lowest", {22'h0, rd_d[25:16]}, 32'h0);
    wr(8'hB0, 32'hF8);
    rd(8'hD4);
    chk("thr highest", {22'h0, rd_d[25:16]}, 32'h372);
    $display("test registers done");
    wr(8'hCC, 32'h4);
    wr(8'hD0, 32'hC);
    wr(8'hC4, 32'h1);
    wr(8'hA8, 32'h5);
    wr(8'hA4, 32'hC0);
    wr(8'hC8, 32'h1);
    fin(4'h0, 40, 1'b1);
    hold(4'h2, 4 * per);
    fin(4'h2, 2 * per + 4, 1'b1);
    $display("test count done");
    hold(4'h4, 3 * per);
    hold(4'h6, 5 * per);
    fin(4'h6, 2 * per + 4, 1'b1);
    wr(8'hA4, 32'h40);
    hold(4'h2, 3 * per);
    hold(4'h4, 3 * per);
    fin(4'h4, 2 * per + 4, 1'b1);
    $display("test mismatch modes done");
    high_g <= 1'b1;
    hold(4'h8, 6 * per);
    high_g <= 1'b0;
    hold(4'h8, 4 * per);
    fin(4'h8, 2 * per + 4, 1'b1);
    $display("test freeze done");
    hold(4'h1, 3 * per);
    sleep_state <= 1'b1;
    hold(4'h1, 4 * per);
    fin(4'h1, 2 * per + 4, 1'b1);
    $display("test wake sleep done");
    // Masked event: status still sets, output stays low
    wr(8'hC4, 32'h0);
    wr(8'hC8, 32'h3);
    wr(8'hA8, 32'h2);
    per = 12;
    hold(4'hA, 10);
    fin(4'hA, 40, 1'b0);
    $display("test flexible rate done");
    wrap_up();
  end
endmodule // odc_orient_debounce_test
`default_nettype wire

/* File: pkg/odc_cfg_if.sv */
// Interface: angle codes out to the decoder and decoded trip angles back
`timescale 1ns/10ps
`default_nettype none
interface odc_cfg_if;
  logic [1:0] flip_code;
  logic [2:0] tilt_lockout_code;
  logic [4:0] pose_threshold_code;
  logic [2:0] pose_hysteresis_code;
  logic [6:0] flip_b2f_deg;
  logic [8:0] tilt_min_dtenth;
  logic [8:0] tilt_max_dtenth;
  logic [9:0] pose_thr_dtenth;
  logic [9:0] pose_l2p_dtenth;
  logic [9:0] pose_p2l_dtenth;
  modport ctrl (output flip_code, tilt_lockout_code, pose_threshold_code,
    pose_hysteresis_code, input flip_b2f_deg, tilt_min_dtenth, tilt_max_dtenth,
    pose_thr_dtenth, pose_l2p_dtenth, pose_p2l_dtenth);
  modport lut (input flip_code, tilt_lockout_code, pose_threshold_code,
    pose_hysteresis_code, output flip_b2f_deg, tilt_min_dtenth, tilt_max_dtenth,
    pose_thr_dtenth, pose_l2p_dtenth, pose_p2l_dtenth);
endinterface
`default_nettype wire

/* File: pkg/odc_pkg.sv */
// Package: register map, field positions and reset values of the orientation debounce block
package odc_pkg;
  localparam logic [7:0] ODC_IDX_STATE = 8'h28;
  localparam logic [7:0] ODC_IDX_SETUP = 8'h29;
  localparam logic [7:0] ODC_IDX_DBCOUNT = 8'h2A;
  localparam logic [7:0] ODC_IDX_FLIPTILT = 8'h2B;
  localparam logic [7:0] ODC_IDX_THRESH = 8'h2C;
  localparam logic [7:0] ODC_IDX_IRQ_STAT = 8'h30;
  localparam logic [7:0] ODC_IDX_IRQ_MASK = 8'h31;
  localparam logic [7:0] ODC_IDX_CTRL = 8'h32;
  localparam logic [7:0] ODC_IDX_RATE_DIV = 8'h33;
  localparam logic [7:0] ODC_IDX_EFF_DIV = 8'h34;
  localparam logic [7:0] ODC_IDX_ANGLES = 8'h35;
  localparam logic [7:0] ODC_IDX_HYS_ANG = 8'h36;
  localparam int ODC_MODE_BIT = 7;
  localparam int ODC_ENABLE_BIT = 6;
  localparam int ODC_FLAG_BIT = 7;
  localparam int ODC_FLIP_LSB = 6;
  localparam int ODC_TILT_LSB = 0;
  localparam int ODC_THR_LSB = 3;
  localparam int ODC_HYS_LSB = 0;
  localparam int ODC_CTRL_ACTIVE_BIT = 0;
  localparam int ODC_CTRL_FLEX_BIT = 1;
  localparam logic [7:0] ODC_SETUP_RST = 8'h80;
  localparam logic [7:0] ODC_DBCOUNT_RST = 8'h00;
  localparam logic [7:0] ODC_FLIPTILT_RST = 8'h44;
  localparam logic [7:0] ODC_THRESH_RST = 8'h84;
  localparam logic [15:0] ODC_RATE_DIV_RST = 16'h00FF;
  localparam logic [15:0] ODC_EFF_DIV_RST = 16'h00FF;
  localparam logic [1:0] ODC_RESP_OKAY = 2'h0;
  localparam logic [1:0] ODC_RESP_SLVERR = 2'h2;
  localparam logic [9:0] ODC_ANGLE_FULL = 10'h384;
endpackage

/* File: rtl/odc_angle_lut.sv */
// Angle decoder: configuration codes to trip angles in degrees or tenths of a degree
`timescale 1ns/10ps
`default_nettype none
module odc_angle_lut
  import odc_pkg::*;
(
  odc_cfg_if.lut cfg
);
  function automatic logic [9:0] thr_angle(input logic [4:0] c);
    logic [9:0] t [32];
    t = '{10'd0, 10'd18, 10'd38, 10'd59, 10'd81, 10'd105, 10'd130, 10'd156,
      10'd184, 10'd214, 10'd244, 10'd276, 10'd310, 10'd344, 10'd379, 10'd414,
      10'd450, 10'd486, 10'd521, 10'd556, 10'd590, 10'd624, 10'd656, 10'd686,
      10'd716, 10'd744, 10'd770, 10'd795, 10'd819, 10'd841, 10'd862, 10'd882};
    return t[c];
  endfunction
  function automatic logic [9:0] hys_angle(input logic [2:0] h);
    logic [9:0] t [8];
    t = '{10'd0, 10'd40, 10'd70, 10'd110, 10'd140, 10'd170, 10'd210, 10'd240};
    return t[h];
  endfunction
  logic [8:0] zmin [8];
  logic [8:0] zmax [8];
  logic [9:0] thr;
  logic [9:0] hys;
  logic [10:0] l2p_sum;
  assign zmin = '{9'd136, 9'd171, 9'd207, 9'd244, 9'd281, 9'd320, 9'd361, 9'd404};
  assign zmax = '{9'd145, 9'd182, 9'd220, 9'd259, 9'd300, 9'd342, 9'd387, 9'd434};
  assign cfg.tilt_min_dtenth = zmin[cfg.tilt_lockout_code];
  assign cfg.tilt_max_dtenth = zmax[cfg.tilt_lockout_code];
  // Back-to-front limit, 80 degrees less 5 per flip code step
  assign cfg.flip_b2f_deg = 7'(7'd80 - 7'(cfg.flip_code) * 7'd5);
  assign thr = thr_angle(cfg.pose_threshold_code);
  assign hys = hys_angle(cfg.pose_hysteresis_code);
  assign cfg.pose_thr_dtenth = thr;
  assign l2p_sum = {1'b0, thr} + {1'b0, hys};
  // Symmetric widening, clamped to the valid angle range
  assign cfg.pose_l2p_dtenth = (l2p_sum > {1'b0, ODC_ANGLE_FULL}) ?
    ODC_ANGLE_FULL : l2p_sum[9:0];
  assign cfg.pose_p2l_dtenth = (hys > thr) ? 10'h000 : 10'(thr - hys);
endmodule // odc_angle_lut
`default_nettype wire

/* File: rtl/odc_orient_debounce.sv */
// Top: orientation debounce, angle configuration registers and AXI4-Lite slave
//
// Notes on behaviour
// - Change flag rises only after new orientation held for programmed sample count, or on first sample after activation.
// - Debounce period ticks from selected rate, or effective rate in flexible mode.
// - Counter resets on standby/active changes either way and wake/sleep changes.
// - Counter frozen while any axis exceeds 1.25 g.
// - Mismatch decrements counter in mode 0, clears it in mode 1.
// - Flip trip code in bits 7:6, reset 01 giving about 75 degrees.
// - Tilt lockout code in bits 2:0, reset 100 giving 28.1 degrees.
// - Lockout codes map to fixed minimum and maximum angle tables.
// - Threshold code in upper five bits, hysteresis lower three; reset 10h and 4.
// - Threshold code maps non-linearly to 0.0 through 88.2 degrees.
// - Hysteresis widens trip points symmetrically about the threshold.
`timescale 1ns/10ps
`default_nettype none
module odc_orient_debounce
  import odc_pkg::*;
#(
  parameter int DIV_W = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [3:0] orient_now,
  input wire logic high_g,
  input wire logic sleep_state,
  output logic pose_changed_flag,
  output logic irq
);
  initial begin
    if (DIV_W < 8 || DIV_W > 16) $error("odc_orient_debounce: DIV_W out of range");
  end
  odc_cfg_if cfg ();
  logic [7:0] setup_ff;
  logic [7:0] turn_debounce_count_ff;
  logic [7:0] fliptilt_ff;
  logic [7:0] thresh_ff;
  logic [1:0] ctrl_ff;
  logic [DIV_W-1:0] rate_div_ff;
  logic [DIV_W-1:0] eff_div_ff;
  logic irq_stat_ff;
  logic irq_mask_ff;
  logic [7:0] cnt_ff;
  logic [3:0] stable_ff;
  logic [3:0] prev_ff;
  logic first_ff;
  logic active_d_ff;
  logic sleep_d_ff;
  logic change_evt;
  logic sample_tick;
  logic [DIV_W-1:0] period;
  logic aw_got_ff;
  logic w_got_ff;
  logic [7:0] aw_addr_ff;
  logic [31:0] w_data_ff;
  logic [3:0] w_strb_ff;
  logic do_write;
  logic wr_hit;
  logic rd_hit;
  logic [31:0] rd_word;
  logic state_read;

  function automatic logic [7:0] idx_of(input logic [7:0] a);
    return {2'b00, a[7:2]};
  endfunction

  function automatic logic is_mapped(input logic [7:0] i);
    return (i >= ODC_IDX_STATE && i <= ODC_IDX_THRESH) ||
      (i >= ODC_IDX_IRQ_STAT && i <= ODC_IDX_HYS_ANG);
  endfunction

  assign cfg.flip_code = fliptilt_ff[ODC_FLIP_LSB +: 2];
  assign cfg.tilt_lockout_code = fliptilt_ff[ODC_TILT_LSB +: 3];
  assign cfg.pose_threshold_code = thresh_ff[ODC_THR_LSB +: 5];
  assign cfg.pose_hysteresis_code = thresh_ff[ODC_HYS_LSB +: 3];
  odc_angle_lut u_lut (
    .cfg(cfg)
  );

  // Flexible mode runs on the effective rate, the others on the selected rate
  assign period = ctrl_ff[ODC_CTRL_FLEX_BIT] ? eff_div_ff : rate_div_ff;
  odc_rate_div #(
    .W(DIV_W)
  ) u_div (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(ctrl_ff[ODC_CTRL_ACTIVE_BIT]),
    .period_cycles(period),
    .tick(sample_tick)
  );

  // Write channel: address and data taken in either order
  assign do_write = aw_got_ff && w_got_ff && !s_axi_bvalid;
  assign wr_hit = do_write && is_mapped(idx_of(aw_addr_ff));
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= ODC_RESP_OKAY;
      aw_addr_ff <= 8'h00;
      w_data_ff <= 32'h0000_0000;
      w_strb_ff <= 4'h0;
    end else begin
      s_axi_awready <= !aw_got_ff && !s_axi_bvalid && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !w_got_ff && !s_axi_bvalid && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_ff <= 1'b1;
        aw_addr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_ff <= 1'b1;
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_got_ff <= 1'b0;
        w_got_ff <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? ODC_RESP_OKAY : ODC_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Configuration registers, writable at any time; the debounce engine samples setup and count per tick, the rest are used every cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      setup_ff <= ODC_SETUP_RST;
      turn_debounce_count_ff <= ODC_DBCOUNT_RST;
      fliptilt_ff <= ODC_FLIPTILT_RST;
      thresh_ff <= ODC_THRESH_RST;
      ctrl_ff <= 2'h0;
      rate_div_ff <= DIV_W'(ODC_RATE_DIV_RST);
      eff_div_ff <= DIV_W'(ODC_EFF_DIV_RST);
      irq_mask_ff <= 1'b0;
    end else if (wr_hit && w_strb_ff[0]) begin
      unique case (idx_of(aw_addr_ff))
        ODC_IDX_SETUP: setup_ff <= w_data_ff[7:0];
        ODC_IDX_DBCOUNT: turn_debounce_count_ff <= w_data_ff[7:0];
        ODC_IDX_FLIPTILT: fliptilt_ff <= w_data_ff[7:0];
        ODC_IDX_THRESH: thresh_ff <= w_data_ff[7:0];
        ODC_IDX_IRQ_MASK: irq_mask_ff <= w_data_ff[0];
        ODC_IDX_CTRL: ctrl_ff <= w_data_ff[1:0];
        ODC_IDX_RATE_DIV: rate_div_ff <= w_data_ff[DIV_W-1:0];
        ODC_IDX_EFF_DIV: eff_div_ff <= w_data_ff[DIV_W-1:0];
        default: ;
      endcase
    end
  end

  // Read channel
  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (idx_of(s_axi_araddr))
      ODC_IDX_STATE: rd_word = {24'h0, pose_changed_flag, stable_ff[3], 3'b000,
        stable_ff[2:0]};
      ODC_IDX_SETUP: rd_word = {24'h0, setup_ff};
      ODC_IDX_DBCOUNT: rd_word = {24'h0, turn_debounce_count_ff};
      ODC_IDX_FLIPTILT: rd_word = {24'h0, fliptilt_ff};
      ODC_IDX_THRESH: rd_word = {24'h0, thresh_ff};
      ODC_IDX_IRQ_STAT: rd_word = {31'h0, irq_stat_ff};
      ODC_IDX_IRQ_MASK: rd_word = {31'h0, irq_mask_ff};
      ODC_IDX_CTRL: rd_word = {30'h0, ctrl_ff};
      ODC_IDX_RATE_DIV: rd_word = 32'(rate_div_ff);
      ODC_IDX_EFF_DIV: rd_word = 32'(eff_div_ff);
      ODC_IDX_ANGLES: rd_word = {6'h0, cfg.pose_thr_dtenth, cfg.tilt_min_dtenth,
        cfg.flip_b2f_deg};
      ODC_IDX_HYS_ANG: rd_word = {3'h0, cfg.tilt_max_dtenth, cfg.pose_l2p_dtenth,
        cfg.pose_p2l_dtenth};
      default: rd_word = 32'h0000_0000;
    endcase
  end
  assign rd_hit = is_mapped(idx_of(s_axi_araddr));
  assign state_read = s_axi_arvalid && s_axi_arready && idx_of(s_axi_araddr) == ODC_IDX_STATE;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= ODC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_hit ? ODC_RESP_OKAY : ODC_RESP_SLVERR;
    end else if (s_axi_rvalid) begin
      s_axi_arready <= 1'b0;
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

  // Debounce engine
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      active_d_ff <= 1'b0;
      sleep_d_ff <= 1'b0;
    end else begin
      active_d_ff <= ctrl_ff[ODC_CTRL_ACTIVE_BIT];
      sleep_d_ff <= sleep_state;
    end
  end
  always_ff @(posedge aclk) begin
    change_evt <= 1'b0;
    if (!aresetn) begin
      cnt_ff <= 8'h00;
      stable_ff <= 4'h0;
      prev_ff <= 4'h0;
      first_ff <= 1'b0;
      change_evt <= 1'b0;
    end else if (active_d_ff != ctrl_ff[ODC_CTRL_ACTIVE_BIT] ||
                 sleep_d_ff != sleep_state) begin
      cnt_ff <= 8'h00;
      // Standby to active re-arms first detection and clears the orientation
      if (ctrl_ff[ODC_CTRL_ACTIVE_BIT] && !active_d_ff) begin
        first_ff <= 1'b1;
        stable_ff <= 4'h0;
        prev_ff <= 4'h0;
      end
    end else if (sample_tick && setup_ff[ODC_ENABLE_BIT] && !high_g) begin
      prev_ff <= orient_now;
      if (first_ff) begin
        first_ff <= 1'b0;
        stable_ff <= orient_now;
        change_evt <= 1'b1;
      end else if (orient_now == stable_ff) begin
        cnt_ff <= 8'h00;
      end else if (orient_now != prev_ff && cnt_ff != 8'h00) begin
        if (setup_ff[ODC_MODE_BIT]) begin
          cnt_ff <= 8'h00;
        end else begin
          cnt_ff <= cnt_ff - 8'h01;
        end
      end else if (cnt_ff + 8'h01 >= turn_debounce_count_ff || cnt_ff == 8'hFF) begin
        cnt_ff <= 8'h00;
        stable_ff <= orient_now;
        change_evt <= 1'b1;
      end else begin
        cnt_ff <= cnt_ff + 8'h01;
      end
    end
  end

  // Set wins over both the state read and the one-write clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pose_changed_flag <= 1'b0;
      irq_stat_ff <= 1'b0;
      irq <= 1'b0;
    end else begin
      pose_changed_flag <= change_evt || (pose_changed_flag && !state_read);
      irq_stat_ff <= change_evt || (irq_stat_ff && !(wr_hit && w_strb_ff[0] &&
        idx_of(aw_addr_ff) == ODC_IDX_IRQ_STAT && w_data_ff[0]));
      irq <= irq_stat_ff && irq_mask_ff;
    end
  end

  a_dbcnt_reset: assert property (@(posedge aclk) disable iff (!aresetn)
    $changed(sleep_state) |=> cnt_ff == 8'h00)
    else $error("debounce counter not reset on wake/sleep change");
  a_freeze_highg: assert property (@(posedge aclk) disable iff (!aresetn)
    high_g && $stable(sleep_state) && $stable(ctrl_ff) |=> $stable(cnt_ff) && !change_evt)
    else $error("debounce counter moved under high acceleration");
  a_mode_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    sample_tick && !high_g && setup_ff[ODC_ENABLE_BIT] && setup_ff[ODC_MODE_BIT] &&
    !first_ff && orient_now != stable_ff && orient_now != prev_ff && cnt_ff != 8'h00 &&
    $stable(sleep_state) && $stable(ctrl_ff) |=> cnt_ff == 8'h00)
    else $error("mismatch did not clear counter");
  a_flag_count: assert property (@(posedge aclk) disable iff (!aresetn)
    change_evt && !$past(first_ff) |-> $past(cnt_ff) + 8'h01 >= $past(turn_debounce_count_ff)
    || $past(cnt_ff) == 8'hFF)
    else $error("orientation accepted before debounce count");
  a_flag_rise: assert property (@(posedge aclk) disable iff (!aresetn)
    change_evt |=> pose_changed_flag)
    else $error("change flag missed an accepted orientation");
  a_flip_default: assert property (@(posedge aclk)
    !aresetn |=> cfg.flip_code == 2'b01 && cfg.flip_b2f_deg == 7'd75)
    else $error("flip code reset wrong");
  a_tilt_default: assert property (@(posedge aclk)
    !aresetn |=> cfg.tilt_min_dtenth == 9'd281 && cfg.tilt_max_dtenth == 9'd300)
    else $error("lockout reset angle wrong");
  a_thr_default: assert property (@(posedge aclk)
    !aresetn |=> cfg.pose_thr_dtenth == 10'd450 && cfg.pose_l2p_dtenth == 10'd590 &&
    cfg.pose_p2l_dtenth == 10'd310)
    else $error("threshold reset wrong");
  a_tick_source: assert property (@(posedge aclk) disable iff (!aresetn)
    ctrl_ff[ODC_CTRL_FLEX_BIT] |-> period == eff_div_ff)
    else $error("flexible mode not on effective rate");
  // Decoder has no clock of its own, so its table is watched from here
  a_tilt_order: assert property (@(posedge aclk) disable iff (!aresetn)
    cfg.tilt_min_dtenth < cfg.tilt_max_dtenth)
    else $error("lockout minimum angle not below maximum");
  a_irq_level: assert property (@(posedge aclk) disable iff (!aresetn)
    irq_stat_ff && irq_mask_ff |=> irq)
    else $error("interrupt not raised");
endmodule // odc_orient_debounce
`default_nettype wire

/* File: rtl/odc_rate_div.sv */
// Sample period divider: one-cycle tick every period_cycles clocks
`timescale 1ns/10ps
`default_nettype none
module odc_rate_div #(
  parameter int W = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic run,
  input wire logic [W-1:0] period_cycles,
  output logic tick
);
  initial begin
    if (W < 2) $error("odc_rate_div: W too small");
  end
  logic [W-1:0] cnt_ff;
  // Period of zero behaves as one so the tick never stalls
  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      cnt_ff <= '0;
      tick <= 1'b0;
    end else if (cnt_ff + W'(1) >= period_cycles) begin
      cnt_ff <= '0;
      tick <= 1'b1;
    end else begin
      cnt_ff <= cnt_ff + W'(1);
      tick <= 1'b0;
    end
  end
  a_tick_spacing: assert property (@(posedge aclk) disable iff (!aresetn)
    tick |=> !tick || (period_cycles <= W'(1)))
    else $error("tick came twice in a row");
endmodule // odc_rate_div
`default_nettype wire
